// File: hw/mct_pkg.sv
// constants, register map and field layout of the Manchester transmitter slice
// assumes a byte-wide CPU data bus with 16-bit addresses and single-bit writes
//
// Contract
// [R1] Status register read-only; writes ignored.
// [R2] Status clears on reset or enable off.
// [R3] Busy flag set during transmission, cleared after.
// [R4] Busy stays set through back-to-back words.
// [R5] Software checks busy clear before reconfiguring.
// [R6] Three modes: stopped, Manchester, bit sequential.
// [R7] Stopped mode sends nothing, releases the pin.
// [R8] Mode bit 7 enables operation.
// [R9] Bit 4 first-bit order, bit 1 format.
// [R10] Bit 0 sets idle pin level.
// [R11] Software clears enable before changing mode bits.
// [R12] Reset values 10H and 00H; write widths.
// [R13] Base clock is peripheral clock over 2^code.
// [R14] Software clears enable before changing prescaler.
// [R15] Bit rate base/(2k), k at least 4.
// [R16] Count sets 1-8 bits; short words use low bits.
// [R17] Manchester halves with a mid-bit transition.
package mct_pkg;

  // -----------------------------------------------------------------
  // register addresses
  // -----------------------------------------------------------------
  localparam logic [15:0] ADDR_STATUS    = 16'hFF47;
  localparam logic [15:0] ADDR_MODE      = 16'hFF4C;
  localparam logic [15:0] ADDR_CLK_SEL   = 16'hFF4D;

  // -----------------------------------------------------------------
  // fields and reset values
  // -----------------------------------------------------------------
  localparam int          MODE_EN_BIT    = 7;
  localparam int          MODE_DIR_BIT   = 4;
  localparam int          MODE_FMT_BIT   = 1;
  localparam int          MODE_IDLE_BIT  = 0;
  localparam logic [7:0]  MODE_MASK      = 8'h93;
  localparam logic [7:0]  MODE_RESET     = 8'h10;
  localparam logic [2:0]  CLK_SEL_RESET  = 3'h0;
  localparam logic [2:0]  CLK_SEL_MAX    = 3'h5;
  localparam logic [4:0]  BAUD_K_MIN     = 5'h04;
  localparam logic [4:0]  PRE_ONES       = 5'h1F;
  localparam logic [6:0]  STATUS_ZEROS   = 7'h00;
  localparam logic [4:0]  CLK_SEL_ZEROS  = 5'h00;
  localparam logic [7:0]  READ_NONE      = 8'h00;

  typedef enum logic {ST_IDLE, ST_SEND} mct_state_t;

endpackage : mct_pkg

// File: hw/mct_tx.sv
// Manchester / bit-sequential serial transmitter with status, mode and prescaler registers
// assumes CPU bus signals and the transmit buffer strobe come from logic on CLK;
// baud field and bit count are held stable by software while enabled
`timescale 1ns/1ps
module mct_tx (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [15:0] BUS_ADDR,
  input  wire logic        BUS_WR,
  input  wire logic [7:0]  BUS_WDATA,
  input  wire logic        BUS_BWR,
  input  wire logic [2:0]  BUS_BSEL,
  input  wire logic        BUS_BVAL,
  input  wire logic        BUS_RD,
  output logic      [7:0]  BUS_RDATA,
  input  wire logic        TX_BUF_WR,
  input  wire logic [7:0]  TX_BUF_DATA,
  input  wire logic [2:0]  TX_BIT_COUNT,
  input  wire logic [4:0]  BAUD_K,
  output logic             CODED_OUT,
  output logic             CODED_OUT_EN_N
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0]          mode_q,    mode_d;
  logic [2:0]          cks_q,     cks_d;
  logic [7:0]          rdata_q,   rdata_d;
  logic [4:0]          pre_q,     pre_d;
  mct_pkg::mct_state_t state_q,   state_d;
  logic [7:0]          word_q,    word_d;
  logic                pend_q,    pend_d;
  logic [7:0]          pdata_q,   pdata_d;
  logic [2:0]          pos_q,     pos_d;
  logic [2:0]          sent_q,    sent_d;
  logic [4:0]          hcnt_q,    hcnt_d;
  logic                half_q,    half_d;
  logic                out_q,     out_d;
  logic                oen_n_q,   oen_n_d;
  logic                en_d;
  logic                busy;
  logic [2:0]          cks_eff;
  logic [4:0]          pre_mask;
  logic                base_tick;
  logic [4:0]          k_last;
  logic                half_tick;
  logic                cur_bit;
  logic [2:0]          start_pos;

  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  // status has no write path at all, so byte and bit writes to it fall away
  always_comb begin
    mode_d  = mode_q;
    cks_d   = cks_q;
    rdata_d = rdata_q;
    if (BUS_WR) begin
      if (BUS_ADDR == mct_pkg::ADDR_MODE) begin
        mode_d = BUS_WDATA & mct_pkg::MODE_MASK;                  // R9
      end else if (BUS_ADDR == mct_pkg::ADDR_CLK_SEL) begin
        cks_d = BUS_WDATA[2:0];                                   // R12
      end
    end else if (BUS_BWR && BUS_ADDR == mct_pkg::ADDR_MODE) begin
      mode_d[BUS_BSEL] = BUS_BVAL;                                // R12
      mode_d           = mode_d & mct_pkg::MODE_MASK;
    end
    if (BUS_RD) begin
      if (BUS_ADDR == mct_pkg::ADDR_STATUS) begin
        rdata_d = {busy, mct_pkg::STATUS_ZEROS};                  // R1
      end else if (BUS_ADDR == mct_pkg::ADDR_MODE) begin
        rdata_d = mode_q;
      end else if (BUS_ADDR == mct_pkg::ADDR_CLK_SEL) begin
        rdata_d = {mct_pkg::CLK_SEL_ZEROS, cks_q};
      end else begin
        rdata_d = mct_pkg::READ_NONE;
      end
    end
  end

  // bit-select writes to the prescaler register are dropped: byte access only
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode_q  <= mct_pkg::MODE_RESET;                             // R12
      cks_q   <= mct_pkg::CLK_SEL_RESET;                          // R12
      rdata_q <= mct_pkg::READ_NONE;
    end else begin
      mode_q  <= mode_d;
      cks_q   <= cks_d;
      rdata_q <= rdata_d;
    end
  end

  // -----------------------------------------------------------------
  // base clock prescaler and half-bit divider
  // -----------------------------------------------------------------
  // prohibited codes 6 and 7 fall back to the slowest legal setting
  assign cks_eff   = (cks_q > mct_pkg::CLK_SEL_MAX) ? mct_pkg::CLK_SEL_MAX : cks_q;
  assign pre_mask  = ~(mct_pkg::PRE_ONES << cks_eff);                 // R13
  assign base_tick = ((pre_q & pre_mask) == pre_mask);               // R13
  assign k_last    = ((BAUD_K < mct_pkg::BAUD_K_MIN) ? mct_pkg::BAUD_K_MIN : BAUD_K) - 5'h01; // R15
  assign half_tick = (state_q == mct_pkg::ST_SEND) && base_tick && (hcnt_q == k_last); // R15
  assign pre_d     = pre_q + 5'h01;

  // -----------------------------------------------------------------
  // transmit sequencer
  // -----------------------------------------------------------------
  assign en_d      = mode_d[mct_pkg::MODE_EN_BIT];                    // R8
  assign busy      = (state_q == mct_pkg::ST_SEND);                  // R3
  assign cur_bit   = word_q[pos_q];
  // short words always take the low bits of the buffer
  assign start_pos = mode_q[mct_pkg::MODE_DIR_BIT] ? 3'h0 : TX_BIT_COUNT; // R16

  always_comb begin
    state_d = state_q;
    word_d  = word_q;
    pend_d  = pend_q;
    pdata_d = pdata_q;
    pos_d   = pos_q;
    sent_d  = sent_q;
    hcnt_d  = hcnt_q;
    half_d  = half_q;
    if (!en_d) begin
      state_d = mct_pkg::ST_IDLE;                                  // R2
      pend_d  = 1'b0;
      hcnt_d  = 5'h00;
      half_d  = 1'b0;
    end else begin
      case (state_q)
        mct_pkg::ST_IDLE: begin
          if (TX_BUF_WR) begin
            state_d = mct_pkg::ST_SEND;                            // R3
            word_d  = TX_BUF_DATA;
            pos_d   = start_pos;
            sent_d  = 3'h0;
            hcnt_d  = 5'h00;
            half_d  = 1'b0;
          end
        end
        mct_pkg::ST_SEND: begin
          if (TX_BUF_WR) begin
            pend_d  = 1'b1;
            pdata_d = TX_BUF_DATA;
          end
          if (base_tick) begin
            hcnt_d = hcnt_q + 5'h01;
          end
          if (half_tick) begin
            hcnt_d = 5'h00;
            half_d = ~half_q;                                      // R17
            if (half_q) begin
              if (sent_q == TX_BIT_COUNT) begin                    // R16
                pos_d  = start_pos;
                sent_d = 3'h0;
                if (pend_q) begin
                  word_d = pdata_q;                                // R4
                  pend_d = TX_BUF_WR;
                end else if (TX_BUF_WR) begin
                  word_d = TX_BUF_DATA;                            // R4
                  pend_d = 1'b0;
                end else begin
                  state_d = mct_pkg::ST_IDLE;                      // R3
                end
              end else begin
                sent_d = sent_q + 3'h1;
                pos_d  = mode_q[mct_pkg::MODE_DIR_BIT] ? pos_q + 3'h1 : pos_q - 3'h1; // R9
              end
            end
          end
        end
        default: state_d = mct_pkg::ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------------
  // manchester: first half carries the inverted bit, second half the bit, so 1 is low-to-high
  always_comb begin
    oen_n_d = ~mode_q[mct_pkg::MODE_EN_BIT];                       // R7
    if (mode_q[mct_pkg::MODE_EN_BIT] && busy) begin
      if (mode_q[mct_pkg::MODE_FMT_BIT]) begin
        out_d = cur_bit;                                           // R6
      end else begin
        out_d = half_q ? cur_bit : ~cur_bit;                       // R17
      end
    end else begin
      out_d = mode_q[mct_pkg::MODE_IDLE_BIT];                      // R10
    end
  end

  // one register stage for every output keeps the pin glitch free
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pre_q   <= 5'h00;
      state_q <= mct_pkg::ST_IDLE;                                 // R2
      word_q  <= 8'h00;
      pend_q  <= 1'b0;
      pdata_q <= 8'h00;
      pos_q   <= 3'h0;
      sent_q  <= 3'h0;
      hcnt_q  <= 5'h00;
      half_q  <= 1'b0;
      out_q   <= 1'b0;
      oen_n_q <= 1'b1;
    end else begin
      pre_q   <= pre_d;
      state_q <= state_d;
      word_q  <= word_d;
      pend_q  <= pend_d;
      pdata_q <= pdata_d;
      pos_q   <= pos_d;
      sent_q  <= sent_d;
      hcnt_q  <= hcnt_d;
      half_q  <= half_d;
      out_q   <= out_d;
      oen_n_q <= oen_n_d;
    end
  end

  assign BUS_RDATA      = rdata_q;
  assign CODED_OUT      = out_q;
  assign CODED_OUT_EN_N = oen_n_q;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  status_read_a: assert property (BUS_RD && !BUS_WR && !BUS_BWR && BUS_ADDR == mct_pkg::ADDR_STATUS // R1
    |=> BUS_RDATA == {$past(busy), mct_pkg::STATUS_ZEROS}) else $error("status read wrong");
  off_clears_a: assert property (!en_d |=> !busy && !pend_q) else $error("busy kept while off"); // R2
  start_busy_a: assert property (en_d && !busy && TX_BUF_WR |=> busy) else $error("no busy on start"); // R3
  b2b_busy_a: assert property (en_d && half_tick && half_q && (pend_q || TX_BUF_WR) |=> busy) // R4
    else $error("busy dropped between words");
  stop_release_a: assert property (!mode_q[mct_pkg::MODE_EN_BIT] |=> CODED_OUT_EN_N) // R7
    else $error("pin driven while stopped");
  idle_level_a: assert property (mode_q[mct_pkg::MODE_EN_BIT] && !busy // R10
    |=> CODED_OUT == $past(mode_q[mct_pkg::MODE_IDLE_BIT])) else $error("idle level wrong");
  mode_reset_a: assert property ($fell(SYS_RST) // R12
    |-> mode_q == mct_pkg::MODE_RESET && cks_q == mct_pkg::CLK_SEL_RESET) else $error("reset value wrong");
  fast_prescale_a: assert property (cks_q == 3'h0 |-> base_tick) else $error("divide by one broken"); // R13
  half_spacing_a: assert property (half_tick |=> !half_tick [*3]) else $error("k below four"); // R15
  mid_flip_a: assert property (en_d && half_tick && !half_q && !mode_q[mct_pkg::MODE_FMT_BIT] // R17
    && mode_d == mode_q |=> ##1 CODED_OUT != $past(CODED_OUT)) else $error("no mid-bit transition");

  start_c: cover property (!busy && TX_BUF_WR && en_d ##1 busy);
  b2b_c: cover property (half_tick && half_q && pend_q);
  stop_c: cover property (busy && !en_d);
  seq_c: cover property (busy && mode_q[mct_pkg::MODE_FMT_BIT] && half_tick);

endmodule : mct_tx

// File: tb/mct_rcv.sv
// remote receiver model: samples the coded line in mid-half and rebuilds the bits
// assumes ARM pulses with the buffer write that opens a burst, HALF in CLK cycles
`timescale 1ns/1ps
module mct_rcv (
  input  wire logic        CLK,
  input  wire logic        ARM,
  input  wire logic        LINE,
  input  wire logic [11:0] HALF,
  input  wire logic [4:0]  NBITS,
  input  wire logic        SEQ,
  output logic      [15:0] RX_WORD,
  output logic      [7:0]  RX_ERR
);
  int   cnt;
  int   p;
  int   h;
  logic first;
  logic [4:0] got;
  // --------------------------------------------------------------
  // half-bit sampling
  // --------------------------------------------------------------
  // mid-half sampling tolerates a first half cut short by a free prescaler
  always @(posedge CLK) begin
    p = cnt - 2;
    h = int'(HALF);
    cnt <= cnt + 1;
    if (ARM) begin
      cnt <= 1;
      got <= 5'h00;
      RX_WORD <= 16'h0000;
      RX_ERR <= 8'h00;
    end else if (p >= 0 && got < NBITS) begin
      if (p % (2 * h) == h / 2)
        first <= LINE;
      if (p % (2 * h) == h + h / 2) begin
        RX_WORD <= {RX_WORD[14:0], LINE};
        got <= got + 5'h01;
        if ((first == LINE) != SEQ)
          RX_ERR <= RX_ERR + 8'h01;
      end
    end
  end
endmodule // mct_rcv

// File: tb/testbench.sv
// self-checking bench for the transmitter: register tasks plus a line receiver
// assumes the design's bus contract (read data settled one cycle after the strobe)
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, wr, bwr, bval, rd_s, txw, arm, seq, out, en_n;
  logic [15:0] addr, rxw;
  logic [7:0]  wdata, rdata, txd, rdv, rxe;
  logic [2:0]  bsel, cnt;
  logic [4:0]  k, nb;
  logic [11:0] half;
  int          fail_count, compares, cycles, i;

  mct_tx mct_tx_inst (.CLK(clk), .SYS_RST(rst), .BUS_ADDR(addr), .BUS_WR(wr), .BUS_WDATA(wdata),
    .BUS_BWR(bwr), .BUS_BSEL(bsel), .BUS_BVAL(bval), .BUS_RD(rd_s), .BUS_RDATA(rdata),
    .TX_BUF_WR(txw), .TX_BUF_DATA(txd), .TX_BIT_COUNT(cnt), .BAUD_K(k), .CODED_OUT(out),
    .CODED_OUT_EN_N(en_n));
  mct_rcv mct_rcv_inst (.CLK(clk), .ARM(arm), .LINE(out), .HALF(half), .NBITS(nb), .SEQ(seq),
    .RX_WORD(rxw), .RX_ERR(rxe));

  // --------------------------------------------------------------
  // clock and hang guard
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // longest run is a few thousand cycles, so this ceiling only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict;
    end
  end

  // --------------------------------------------------------------
  // bus tasks and checks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    @(negedge clk);
    rdv = rdata;
  endtask
  task automatic wrb(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic bitw(input logic [15:0] a, input logic [2:0] s, input logic v);
    @(negedge clk);
    addr = a;
    bsel = s;
    bval = v;
    bwr = 1'b1;
    @(negedge clk);
    bwr = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, input logic a);
    @(negedge clk);
    txd = d;
    txw = 1'b1;
    arm = a;
    @(negedge clk);
    txw = 1'b0;
    arm = 1'b0;
  endtask
  task automatic wait_idle;
    rdv = 8'h80;
    for (int j = 0; j < 2000 && rdv !== 8'h00; j++)
      rd(16'hFF47);
    chk(rdv, 8'h00);
  endtask
  // one word: prescaler, mode, baud and count set while stopped, as software must
  task automatic xfer(input logic [7:0] m, input logic [2:0] cs, input logic [4:0] kk,
                      input logic [2:0] n, input logic [7:0] d, input logic [15:0] e);
    wrb(16'hFF4D, {5'h00, cs});
    k = kk;
    cnt = n;
    nb = {2'b00, n} + 5'h01;
    seq = m[1];
    // prohibited clock codes run at the slowest legal rate
    half = 12'((kk < 5'h04) ? 5'h04 : kk) << ((cs > 3'h5) ? 3'h5 : cs);
    wrb(16'hFF4C, m);
    send(d, 1'b1);
    rd(16'hFF47);
    chk(rdv, 8'h80);
    chk(en_n, 1'b0);
    wait_idle;
    chk(rxw, e);
    chk(rxe, 8'h00);
    chk(out, m[0]);
    wrb(16'hFF4C, 8'h00);
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {rst, wr, bwr, bval, rd_s, txw, arm, seq} = 8'hFF & 8'h80;
    {addr, wdata, txd, bsel, cnt, k, nb, half} = '0;
    fail_count = 0;
    compares = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(16'hFF4C);
    chk(rdv, 8'h10);
    rd(16'hFF4D);
    chk(rdv, 8'h00);
    rd(16'hFF47);
    chk(rdv, 8'h00);
    wrb(16'hFF47, 8'hFF);
    rd(16'hFF47);
    chk(rdv, 8'h00);
    bitw(16'hFF47, 3'h7, 1'b1);
    rd(16'hFF47);
    chk(rdv, 8'h00);
    wrb(16'hFF4D, 8'h03);
    bitw(16'hFF4D, 3'h2, 1'b1);
    rd(16'hFF4D);
    chk(rdv, 8'h03);
    wrb(16'hFF4C, 8'h6C);
    bitw(16'hFF4C, 3'h0, 1'b1);
    rd(16'hFF4C);
    chk(rdv, 8'h01);
    chk(en_n, 1'b1);
    xfer(8'h80, 3'h0, 5'h02, 3'h7, 8'hA5, 16'h00A5);
    xfer(8'h91, 3'h0, 5'h05, 3'h2, 8'hFE, 16'h0003);
    xfer(8'h82, 3'h0, 5'h04, 3'h7, 8'h3C, 16'h003C);
    for (i = 1; i < 6; i++)
      xfer(8'h80, 3'(i), 5'h04, 3'h1, 8'h02, 16'h0002);
    xfer(8'h80, 3'h7, 5'h04, 3'h0, 8'h01, 16'h0001);
    xfer(8'h93, 3'h1, 5'h1F, 3'h3, 8'h09, 16'h0009);
    // back-to-back: second word queued while the first is on the line
    xfer(8'h80, 3'h0, 5'h04, 3'h7, 8'h00, 16'h0000);
    nb = 5'h10;
    wrb(16'hFF4C, 8'h80);
    send(8'hC3, 1'b1);
    send(8'h5A, 1'b0);
    for (i = 0; i < 40; i++) begin
      rd(16'hFF47);
      chk(rdv, 8'h80);
    end
    wait_idle;
    chk(rxw, 16'hC35A);
    // abort mid-word, then a buffer write while stopped
    send(8'hFF, 1'b1);
    wrb(16'hFF4C, 8'h00);
    rd(16'hFF47);
    chk(rdv, 8'h00);
    chk(en_n, 1'b1);
    send(8'hFF, 1'b1);
    rd(16'hFF47);
    chk(rdv, 8'h00);
    // reset in mid-word: busy and registers return to their reset state
    wrb(16'hFF4C, 8'h91);
    send(8'h0F, 1'b1);
    rd(16'hFF47);
    chk(rdv, 8'h80);
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(16'hFF47);
    chk(rdv, 8'h00);
    rd(16'hFF4C);
    chk(rdv, 8'h10);
    chk(en_n, 1'b1);
    chk(out, 1'b0);
    print_verdict;
  end
endmodule // testbench
